//--- core/gpio_pkg.sv
package gpio_pkg;

   localparam int NPIN = 8;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_DIR = 6'h00;
   localparam logic [5:0] IDX_DIRSET = 6'h01;
   localparam logic [5:0] IDX_DIRCLR = 6'h02;
   localparam logic [5:0] IDX_DIRTGL = 6'h03;
   localparam logic [5:0] IDX_OUT = 6'h04;
   localparam logic [5:0] IDX_OUTSET = 6'h05;
   localparam logic [5:0] IDX_OUTCLR = 6'h06;
   localparam logic [5:0] IDX_OUTPUT_TOGGLE_REG = 6'h07;
   localparam logic [5:0] IDX_IN = 6'h08;
   localparam logic [5:0] IDX_FLAGS = 6'h09;
   localparam logic [5:0] IDX_PORTCTRL = 6'h0a;
   localparam logic [5:0] IDX_PINCTL = 6'h10;
   localparam logic [5:0] IDX_AL_DIR = 6'h18;
   localparam logic [5:0] IDX_AL_OUT = 6'h19;
   localparam logic [5:0] IDX_AL_IN = 6'h1a;
   localparam logic [5:0] IDX_AL_FLAGS = 6'h1b;

   // pin control fields; SLEW_BIT is in port control
   localparam int INV_BIT = 7;
   localparam int PULL_BIT = 3;
   localparam int SENSE_LSB = 0;
   localparam int SENSE_W = 3;
   localparam int SLEW_BIT = 0;

   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_ANY = 3'h1;
   localparam logic [2:0] SENSE_RISE = 3'h2;
   localparam logic [2:0] SENSE_FALL = 3'h3;
   localparam logic [2:0] SENSE_OFF = 3'h4;
   localparam logic [2:0] SENSE_LOW = 3'h5;

   // pins with fully asynchronous sensing
   localparam logic [7:0] FULL_ASYNC = 8'h44;
   localparam logic [1:0] DEAD_CYC = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_type;

   typedef struct packed {
      logic [7:0] dir_en;
      logic [7:0] dir;
      logic [7:0] out_en;
      logic [7:0] out;
      logic [7:0] pull_en;
      logic [7:0] pull;
   } ovr_type;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] out;
      logic [7:0] flags;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] prev;
      logic slew;
      logic [7:0][7:0] pctl;
      logic [7:0][1:0] dead;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [7:0] wdata;
      logic wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } port_state_type;

   localparam port_state_type ST_RST = '0;

endpackage

//--- core/gpio_pin_config_sense.sv
`timescale 1ns/1ps
module gpio_pin_config_sense (
   input wire logic aclk,
   input wire logic aresetn,
   input wire gpio_pkg::axi_req_type axi_req,
   output gpio_pkg::axi_rsp_type axi_rsp,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pull_en,
   input wire gpio_pkg::ovr_type ovr,
   output logic [7:0] sync_in,
   output logic [7:0] pin_event,
   output logic slew_limit,
   output logic irq,
   output logic wake
);
   import gpio_pkg::*;

   port_state_type st_r;
   port_state_type st_nxt;
   logic [7:0] inv;
   logic [7:0] pullb;
   logic [7:0] off;
   logic [7:0] src_en;
   logic [7:0][2:0] sense;
   logic [7:0] in_view;
   logic [7:0] pin_v;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] set_v;
   logic [7:0] clr;
   logic [7:0] ctl_wr;
   logic [7:0] stop_wake;
   logic [6:0] wdec;
   logic [6:0] rdec;

   // alias decode shared
   // alias indices fold onto the regular ones, so both paths share one decode
   function automatic logic [6:0] reg_decode(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      reg_decode = {1'b0, idx};
      if (addr[1:0] != 2'h0) begin
         reg_decode = {1'b0, idx};
      end else if (idx == IDX_AL_DIR) begin
         reg_decode = {1'b1, IDX_DIR};
      end else if (idx == IDX_AL_OUT) begin
         reg_decode = {1'b1, IDX_OUT};
      end else if (idx == IDX_AL_IN) begin
         reg_decode = {1'b1, IDX_IN};
      end else if (idx == IDX_AL_FLAGS) begin
         reg_decode = {1'b1, IDX_FLAGS};
      end else if (idx <= IDX_PORTCTRL) begin
         reg_decode = {1'b1, idx};
      end else if (idx >= IDX_PINCTL && idx < IDX_AL_DIR) begin
         reg_decode = {1'b1, idx};
      end
   endfunction

   always_comb begin
      st_nxt = st_r;
      clr = 8'h00;
      ctl_wr = 8'h00;
      for (int i = 0; i < NPIN; i++) begin
         inv[i] = st_r.pctl[i][INV_BIT];
         pullb[i] = st_r.pctl[i][PULL_BIT];
         sense[i] = st_r.pctl[i][SENSE_LSB +: SENSE_W];
         off[i] = (sense[i] == SENSE_OFF);
         src_en[i] = (sense[i] != SENSE_NONE) && !off[i];
      end

      st_nxt.s1 = pin_in;
      // held edge may surface on re-enable
      st_nxt.s2 = (st_r.s2 & off) | (st_r.s1 & ~off);
      in_view = st_r.s2 ^ inv;
      pin_v = pin_in ^ inv;
      // invert flips view, prev keeps old value
      rise = in_view & ~st_r.prev;
      fall = ~in_view & st_r.prev;
      st_nxt.prev = in_view;

      // register writes
      wdec = reg_decode(st_r.awaddr);
      if (st_r.aw_got && st_r.w_got) begin
         if (wdec[6] && st_r.wstb) begin
            if (wdec[5:0] == IDX_DIR) begin
               st_nxt.dir = st_r.wdata;
            end else if (wdec[5:0] == IDX_DIRSET) begin
               st_nxt.dir = st_r.dir | st_r.wdata;
            end else if (wdec[5:0] == IDX_DIRCLR) begin
               st_nxt.dir = st_r.dir & ~st_r.wdata;
            end else if (wdec[5:0] == IDX_DIRTGL) begin
               st_nxt.dir = st_r.dir ^ st_r.wdata;
            end else if (wdec[5:0] == IDX_OUT) begin
               st_nxt.out = st_r.wdata;
            end else if (wdec[5:0] == IDX_OUTSET) begin
               st_nxt.out = st_r.out | st_r.wdata;
            end else if (wdec[5:0] == IDX_OUTCLR) begin
               st_nxt.out = st_r.out & ~st_r.wdata;
            end else if (wdec[5:0] == IDX_OUTPUT_TOGGLE_REG || wdec[5:0] == IDX_IN) begin
               st_nxt.out = st_r.out ^ st_r.wdata;
            end else if (wdec[5:0] == IDX_FLAGS) begin
               clr = st_r.wdata;
            end else if (wdec[5:0] == IDX_PORTCTRL) begin
               st_nxt.slew = st_r.wdata[SLEW_BIT];
            end else begin
               st_nxt.pctl[wdec[2:0]] = st_r.wdata;
               ctl_wr[wdec[2:0]] = 1'b1;
            end
         end
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wdec[6] ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_req.awvalid && !st_r.aw_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st_r.w_got && !st_r.bvalid) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = axi_req.wdata[7:0];
         st_nxt.wstb = axi_req.wstrb[0];
      end
      if (st_r.bvalid && axi_req.bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // register reads
      rdec = reg_decode(axi_req.araddr);
      if (st_r.rvalid && axi_req.rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (axi_req.arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = rdec[6] ? RESP_OKAY : RESP_SLVERR;
         if (!rdec[6]) begin
            st_nxt.rdata = 8'h00;
         end else if (rdec[5:0] <= IDX_DIRTGL) begin
            st_nxt.rdata = st_r.dir;
         end else if (rdec[5:0] <= IDX_OUTPUT_TOGGLE_REG) begin
            st_nxt.rdata = st_r.out;
         end else if (rdec[5:0] == IDX_IN) begin
            st_nxt.rdata = in_view;
         end else if (rdec[5:0] == IDX_FLAGS) begin
            st_nxt.rdata = st_r.flags;
         end else if (rdec[5:0] == IDX_PORTCTRL) begin
            st_nxt.rdata = {7'h00, st_r.slew};
         end else begin
            st_nxt.rdata = st_r.pctl[rdec[2:0]];
         end
      end

      // sensing, dead time and flags
      for (int i = 0; i < NPIN; i++) begin
         set_v[i] = 1'b0;
         stop_wake[i] = 1'b0;
         case (sense[i])
            SENSE_ANY: begin
               set_v[i] = rise[i] | fall[i];
               stop_wake[i] = pin_v[i] != st_r.prev[i];
            end
            SENSE_RISE: begin
               set_v[i] = rise[i];
               stop_wake[i] = FULL_ASYNC[i] & pin_v[i] & ~st_r.prev[i];
            end
            SENSE_FALL: begin
               set_v[i] = fall[i];
               stop_wake[i] = FULL_ASYNC[i] & ~pin_v[i] & st_r.prev[i];
            end
            SENSE_LOW: begin
               set_v[i] = ~in_view[i];
               stop_wake[i] = ~pin_v[i];
            end
            default: begin
               set_v[i] = 1'b0;
               stop_wake[i] = 1'b0;
            end
         endcase
         // a rewrite drops the pending condition
         // an invert change in a rewrite still gives an edge one cycle later
         set_v[i] = set_v[i] & ~ctl_wr[i] & (st_r.dead[i] == 2'h0);
         if (set_v[i]) begin
            st_nxt.dead[i] = DEAD_CYC;
         end else if (st_r.dead[i] != 2'h0) begin
            st_nxt.dead[i] = st_r.dead[i] - 2'h1;
         end
      end
      // flag set; set wins over clear
      st_nxt.flags = (st_r.flags & ~clr) | set_v;
   end

   // single clock, sync halts with it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // override per aspect, otherwise port logic
   assign pin_oe = (ovr.dir_en & ovr.dir) | (~ovr.dir_en & st_r.dir);
   assign pin_out = ((ovr.out_en & ovr.out) | (~ovr.out_en & st_r.out)) ^ inv;
   assign pull_en = (ovr.pull_en & ovr.pull) | (~ovr.pull_en & pullb & ~pin_oe);
   // events only leave, none come in
   // level events straight from the pin
   assign pin_event = pin_v & ~off;
   assign sync_in = in_view;
   assign slew_limit = st_r.slew;
   // request while an enabled flag is set
   assign irq = |(st_r.flags & src_en);
   // wake works with the clock stopped, except rise/fall sensing on pins outside FULL_ASYNC
   assign wake = irq | (|stop_wake);

   assign axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
   assign axi_rsp.wready = !st_r.w_got && !st_r.bvalid;
   assign axi_rsp.bvalid = st_r.bvalid;
   assign axi_rsp.bresp = st_r.bresp;
   assign axi_rsp.arready = !st_r.rvalid;
   assign axi_rsp.rvalid = st_r.rvalid;
   assign axi_rsp.rdata = {24'h000000, st_r.rdata};
   assign axi_rsp.rresp = st_r.rresp;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [7:0] w1c_v;
   assign w1c_v = clr & ~set_v;

   sequence wr_both_held;
      st_r.aw_got && st_r.w_got;
   endsequence

   sequence pinctl_write;
      wr_both_held ##0 st_r.wstb && st_r.awaddr[7:5] == 3'h2 && st_r.awaddr[1:0] == 2'h0;
   endsequence

   pinctl_store_a: assert property (
      pinctl_write |=> st_r.pctl[$past(st_r.awaddr[4:2])] == $past(st_r.wdata))
      else $error("pin control byte not stored");

   pull_gate_a: assert property (
      (pull_en & ~ovr.pull_en & pin_oe) == 8'h00)
      else $error("pull-up on while pin drives");

   // stages still hold reset zeros for two edges after release
   sync_depth_a: assert property (
      $past(aresetn) && $past(aresetn, 2) |->
      ((st_r.s2 ^ $past(pin_in, 2)) & ~$past(off) & ~$past(off, 2)) == 8'h00)
      else $error("synchroniser depth wrong");

   input_hold_a: assert property (
      ((st_r.s2 ^ $past(st_r.s2)) & $past(off)) == 8'h00)
      else $error("input moved while disabled");

   flag_set_a: assert property (
      (|set_v) |=> (st_r.flags & $past(set_v)) == $past(set_v))
      else $error("sense condition lost");

   flag_clear_a: assert property (
      (|w1c_v) |=> (st_r.flags & $past(w1c_v)) == 8'h00)
      else $error("flag not cleared by write one");

   irq_hold_a: assert property (
      irq && clr == 8'h00 && !(|ctl_wr) |=> irq)
      else $error("request dropped without clear");

   dead_time_a: assert property (
      (set_v & ($past(set_v) | $past(set_v, 2) | $past(set_v, 3))) == 8'h00)
      else $error("condition taken inside dead time");

   event_zero_a: assert property (
      (pin_event & off) == 8'h00)
      else $error("event high with buffer off");

   wr_resp_a: assert property (
      wr_both_held |=> st_r.bvalid ##0 !st_r.aw_got && !st_r.w_got)
      else $error("write answer missing");

   sequence toggle_write;
      wr_both_held ##0 st_r.wstb && wdec[6] && (wdec[5:0] == IDX_OUTPUT_TOGGLE_REG || wdec[5:0] == IDX_IN);
   endsequence

   sequence read_taken;
      axi_req.arvalid && axi_rsp.arready;
   endsequence

   sequence bad_write;
      wr_both_held ##0 !wdec[6];
   endsequence

   toggle_out_a: assert property (
      toggle_write |=> st_r.out == ($past(st_r.out) ^ $past(st_r.wdata)))
      else $error("output bits not toggled");

   read_answer_a: assert property (
      read_taken |=> st_r.rvalid)
      else $error("read answer missing");

   // data must not move while the master stalls
   read_hold_a: assert property (
      st_r.rvalid && !axi_req.rready |=> st_r.rvalid && $stable(st_r.rdata))
      else $error("read answer changed early");

   write_error_a: assert property (
      bad_write |=> st_r.bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   busy_block_a: assert property (
      st_r.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write taken while answer pending");

   irq_cause_a: assert property (
      irq |-> st_r.flags != 8'h00)
      else $error("request without flag");

   wake_irq_a: assert property (
      irq |-> wake)
      else $error("request without wake");

   drive_inv_a: assert property (
      ((pin_out ^ st_r.out ^ inv) & ~ovr.out_en) == 8'h00)
      else $error("drive level not inverted");

   dir_override_a: assert property (
      ((pin_oe ^ ovr.dir) & ovr.dir_en | (pin_oe ^ st_r.dir) & ~ovr.dir_en) == 8'h00)
      else $error("direction source wrong");

   pull_on_a: assert property (
      (pullb & ~ovr.pull_en & ~pin_oe & ~pull_en) == 8'h00)
      else $error("pull-up missing on input");

   event_level_a: assert property (
      ((pin_event ^ pin_in ^ inv) & ~off) == 8'h00)
      else $error("event differs from pin");

   sense_drop_a: assert property (
      (set_v & ctl_wr) == 8'h00)
      else $error("condition kept during rewrite");

   // a zero written to the flags must leave them alone
   flag_keep_a: assert property (
      st_r.flags != 8'h00 |=>
      (st_r.flags & $past(st_r.flags & ~clr)) == $past(st_r.flags & ~clr))
      else $error("flag lost without clear");

endmodule

//--- tb/pad_model.sv
`timescale 1ns/1ps
module pad_model (
   input wire logic aclk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pull_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_lvl,
   output logic [7:0] pin_in
);
   logic [7:0] lvl_r = 8'h00;
   logic [7:0] float_r = 8'h00;
   assign pin_in = lvl_r;
   always @(posedge aclk) begin
      // undriven pins wander so a stale level never passes for a value
      float_r <= ~float_r;
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i])
            lvl_r[i] <= pin_out[i];
         // external level held, cut short when the pin drives
         else if (ext_en[i])
            lvl_r[i] <= ext_lvl[i];
         else if (pull_en[i])
            lvl_r[i] <= 1'b1;
         else
            lvl_r[i] <= float_r[i];
      end
   end
endmodule

//--- tb/gpio_pin_config_sense_test.sv
`timescale 1ns/1ps
module gpio_pin_config_sense_test;
   import gpio_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   axi_req_type req = '0;
   axi_rsp_type rsp;
   ovr_type ovr = '0;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_lvl = 8'h00;
   logic [7:0] pin_in, pin_out, pin_oe, pull_en, sync_in, pin_event;
   logic slew_limit, irq, wake;
   logic [9:0] exp_q[$];
   int err_total = 0;
   int check_count = 0;
   int seed = 14;
   logic [7:0] r, e;
   logic [2:0] sc[6] = '{SENSE_NONE, SENSE_ANY, SENSE_RISE, SENSE_FALL, SENSE_OFF, SENSE_LOW};
   logic [5:0] ridx[5] = '{IDX_DIR, IDX_OUT, IDX_FLAGS, IDX_PORTCTRL, IDX_PINCTL};

   gpio_pin_config_sense uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .ovr(ovr),
      .sync_in(sync_in), .pin_event(pin_event), .slew_limit(slew_limit), .irq(irq),
      .wake(wake));
   pad_model pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
      .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

   always #10 aclk = ~aclk;

   task automatic bad(input string m);
      err_total++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      check_count++;
      if (got !== exp)
         bad(m);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rs = 2'h0);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      chk({6'h00, rsp.bresp}, {6'h00, rs}, "write response");
      req.bready <= 1'b0;
      @(posedge aclk);
   endtask

   // the expectation is noted here; the monitor below compares it
   task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rs = 2'h0);
      exp_q.push_back({rs, d});
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      if (rsp.rvalid === 1'b1 && req.rready) begin
         check_count++;
         if (exp_q.size() == 0)
            bad("read with no note");
         else if ({rsp.rresp, rsp.rdata} !== {exp_q[0][9:8], 24'h0, exp_q[0][7:0]})
            bad("read data or response");
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   end

   initial begin
      wt(5);
      aresetn <= 1'b1;
      wt(1);
      foreach (ridx[i]) rd(ridx[i], 8'h00);
      rd(6'h0b, 8'h00, RESP_SLVERR);
      wr(6'h0b, 8'h55, RESP_SLVERR);
      wr(IDX_PINCTL + 6'h07, 8'h08);
      rd(IDX_PINCTL + 6'h07, 8'h08);
      rd(IDX_PINCTL + 6'h06, 8'h00);
      chk(pull_en, 8'h80, "pull on input");
      wr(IDX_DIRSET, 8'hff);
      chk(pull_en, 8'h00, "pull on output");
      wr(IDX_PORTCTRL, 8'h01);
      chk({7'h0, slew_limit}, 8'h01, "slew bit");
      $display("registers done");
      r = 8'($random(seed));
      wr(IDX_OUT, r);
      wr(IDX_OUTPUT_TOGGLE_REG, 8'h0f);
      wr(IDX_IN, 8'hf0);
      rd(IDX_OUT, ~r);
      chk(pin_out, ~r, "toggled drive");
      wr(IDX_AL_OUT, 8'h5a);
      rd(IDX_OUTSET, 8'h5a);
      rd(IDX_AL_DIR, 8'hff);
      wt(4);
      rd(IDX_AL_IN, 8'h5a);
      wr(IDX_PINCTL, 8'h80);
      chk(pin_out, 8'h5b, "inverted drive");
      wt(4);
      rd(IDX_IN, 8'h5a);
      chk(pin_event, 8'h5a, "level events");
      ovr.out_en <= 8'h04;
      ovr.out <= 8'h04;
      ovr.dir_en <= 8'h10;
      wt(1);
      chk(pin_out, 8'h5f, "override drive");
      chk(pin_oe, 8'hef, "override direction");
      ovr <= '0;
      $display("output paths done");
      wr(IDX_AL_DIR, 8'h00);
      wr(IDX_PINCTL, 8'h00);
      ext_en <= 8'hff;
      wt(4);
      foreach (sc[i]) begin
         e = (sc[i] != SENSE_NONE && sc[i] != SENSE_OFF) ? 8'h02 : 8'h00;
         wr(IDX_PINCTL + 6'h01, {5'h0, sc[i]});
         wr(IDX_FLAGS, 8'hff);
         ext_lvl <= 8'h02;
         wt(4);
         if (sc[i] == SENSE_OFF) begin
            chk(pin_event, 8'h00, "event while off");
            chk(sync_in, 8'h00, "input frozen");
         end
         ext_lvl <= 8'h00;
         wt(6);
         rd(IDX_AL_FLAGS, e);
         chk({7'h0, irq}, e >> 1, "request level");
         if (e[1])
            chk({7'h0, wake}, 8'h01, "wake running");
         wr(IDX_FLAGS, 8'h00);
         chk({7'h0, irq}, e >> 1, "zero write keeps");
         // a held low level would set the flag again at once
         if (sc[i] == SENSE_LOW) begin
            ext_lvl <= 8'h02;
            wt(4);
         end
         wr(IDX_FLAGS, e);
         chk({7'h0, irq}, 8'h00, "one write clears");
      end
      $display("sensing done");
      if (exp_q.size() != 0)
         bad("reads left unanswered");
      stop_test();
   end

   initial begin
      wt(6000);
      bad("timeout");
      stop_test();
   end
endmodule
